// ---- nrcc_pkg.sv ----
// Purpose: Shared constants for the node reset and clock configuration block.
// Assumes: Registers are addressed by their configuration register number.
// Notes: The mode pin reset values are neutral defaults.
package nrcc_pkg;
    // Configuration register numbers.
    localparam logic [7:0] NRCC_REG_RESET_MODE = 8'h50;
    localparam logic [7:0] NRCC_REG_OSC_FREQ = 8'h51;
    // Reset and mode control field positions.
    localparam int NRCC_BIT_SYS_RST = 0;
    localparam int NRCC_BIT_TILE_RST = 1;
    localparam int NRCC_BIT_USB_EN = 2;
    localparam int NRCC_BIT_USB_ACC = 3;
    localparam int NRCC_POS_MODE = 16;
    localparam int NRCC_BIT_MODE_TRI = 24;
    // Reset values.
    localparam logic NRCC_USB_EN_RST = 1'b0;
    localparam logic NRCC_USB_ACC_RST = 1'b0;
    localparam logic [1:0] NRCC_MODE_RST = 2'h0;
    localparam logic NRCC_MODE_TRI_RST = 1'b1;
    localparam logic [6:0] NRCC_FREQ_RST = 7'h19;
    // Accepted oscillator frequency range in MHz.
    localparam logic [6:0] NRCC_FREQ_MIN = 7'h05;
    localparam logic [6:0] NRCC_FREQ_MAX = 7'h64;
    // Timing counts.
    localparam int NRCC_SYS_RESET_CYCLES = 524288;
    localparam logic [9:0] NRCC_US_PER_MS = 10'h3e8;
    localparam int NRCC_TILE_RESET_US = 16;
    localparam int NRCC_WDOG_TIMEOUT_MS = 1000;
    // Sequencer states.
    typedef enum logic [2:0] {
        NRCC_ST_RUN = 3'b001,
        NRCC_ST_SYS = 3'b010,
        NRCC_ST_TILE = 3'b100
    } nrcc_state_t;
endpackage

// ---- nrcc_tick_gen.sv ----
// Purpose: Microsecond and millisecond tick enables from the frequency field.
// Assumes: clk runs at the frequency held in freq_mhz.
// Notes: A lower frequency value than the current count wraps at once.
`timescale 1ns/1ps
`default_nettype none
module nrcc_tick_gen
    import nrcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Programmed oscillator frequency in MHz.
    input wire logic [6:0] freq_mhz,
    // Tick enables.
    output logic us_tick,
    output logic ms_tick
);
    logic [6:0] us_cnt_q;
    logic [6:0] us_cnt_d;
    logic [9:0] ms_cnt_q;
    logic [9:0] ms_cnt_d;
    logic us_tick_q;
    logic us_tick_d;
    logic ms_tick_q;
    logic ms_tick_d;

    always_comb
    begin
        us_cnt_d = us_cnt_q + 7'h01;
        ms_cnt_d = ms_cnt_q;
        us_tick_d = 1'b0;
        ms_tick_d = 1'b0;
        if (us_cnt_q >= freq_mhz - 7'h01)
        begin
            us_cnt_d = 7'h00;
            us_tick_d = 1'b1;
            if (ms_cnt_q == NRCC_US_PER_MS - 10'h001)
            begin
                ms_cnt_d = 10'h000;
                ms_tick_d = 1'b1;
            end
            else
            begin
                ms_cnt_d = ms_cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            us_cnt_q <= 7'h00;
            ms_cnt_q <= 10'h000;
            us_tick_q <= 1'b0;
            ms_tick_q <= 1'b0;
        end
        else
        begin
            us_cnt_q <= us_cnt_d;
            ms_cnt_q <= ms_cnt_d;
            us_tick_q <= us_tick_d;
            ms_tick_q <= ms_tick_d;
        end
    end

    assign us_tick = us_tick_q;
    assign ms_tick = ms_tick_q;
endmodule
`default_nettype wire

// ---- nrcc_node_reset.sv ----
// Purpose: Reset sequencer and mode control of the analogue config node.
// Assumes: clk is the oscillator clock; all inputs synchronous to it.
// Notes: Config requests are single-cycle strobes; any response comes one cycle later.
`timescale 1ns/1ps
`default_nettype none
module nrcc_node_reset
    import nrcc_pkg::*;
#(
    parameter int SYS_RESET_CYCLES = NRCC_SYS_RESET_CYCLES,
    parameter int TILE_RESET_US = NRCC_TILE_RESET_US,
    parameter logic [15:0] WDOG_TIMEOUT_MS = 16'(NRCC_WDOG_TIMEOUT_MS)
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Hardware reset sources.
    input wire logic ext_reset_n,
    input wire logic brownout,
    input wire logic sleep_seq,
    input wire logic clk_src_change,
    // Watchdog control.
    input wire logic wdog_enable,
    input wire logic wdog_kick,
    // Configuration request.
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic cfg_resp_req,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    // Configuration response.
    output logic rsp_valid,
    output logic rsp_nack,
    output logic [31:0] rsp_rdata,
    // Reset outputs.
    output logic sys_reset,
    output logic tile_reset,
    // Mode pins and USB controls.
    output logic [1:0] mode_pins_out,
    output logic mode_pins_oe,
    output logic usb_enable,
    output logic usb_regs_reset,
    output logic usb_reg_access_en,
    // Sleep real-time clock tick.
    output logic sleep_rtc_tick
);
    localparam int CW = $clog2(SYS_RESET_CYCLES);

    nrcc_state_t state_q;
    nrcc_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [15:0] wdog_cnt_q;
    logic [15:0] wdog_cnt_d;
    logic wdog_exp_q;
    logic wdog_exp_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic oe_q;
    logic oe_d;
    logic usb_en_q;
    logic usb_en_d;
    logic usb_acc_q;
    logic usb_acc_d;
    logic [6:0] freq_q;
    logic [6:0] freq_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic rsp_nack_q;
    logic rsp_nack_d;
    logic [31:0] rsp_rdata_q;
    logic [31:0] rsp_rdata_d;
    logic sys_rst_q;
    logic tile_rst_q;
    logic rtc_q;
    logic usb_rst_q;
    logic us_tick;
    logic ms_tick;
    logic wr_rm;
    logic wr_freq;
    logic sw_sys;
    logic sw_tile;
    logic sys_src;
    logic tile_src;
    logic freq_ok;

    nrcc_tick_gen u_tick (
        .clk(clk),
        .reset(reset),
        .freq_mhz(freq_q),
        .us_tick(us_tick),
        .ms_tick(ms_tick)
    );

    assign wr_rm = cfg_valid && cfg_write && cfg_addr == NRCC_REG_RESET_MODE;
    assign wr_freq = cfg_valid && cfg_write && cfg_addr == NRCC_REG_OSC_FREQ;
    assign sw_sys = wr_rm && cfg_wdata[NRCC_BIT_SYS_RST];
    assign sw_tile = wr_rm && cfg_wdata[NRCC_BIT_TILE_RST];
    assign freq_ok = cfg_wdata[31:7] == 25'h0000000 &&
        cfg_wdata[6:0] >= NRCC_FREQ_MIN && cfg_wdata[6:0] <= NRCC_FREQ_MAX;
    assign sys_src = !ext_reset_n || brownout || wdog_exp_q || sw_sys;
    assign tile_src = sleep_seq || clk_src_change || sw_tile;

    // Reset sequencer: system count, then processor reset delay.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            NRCC_ST_RUN:
            begin
                cnt_d = '0;
                if (sys_src)
                    state_d = NRCC_ST_SYS;
                else if (tile_src)
                    state_d = NRCC_ST_TILE;
            end
            NRCC_ST_SYS:
            begin
                if (sys_src)
                    cnt_d = '0;
                else if (cnt_q == CW'(SYS_RESET_CYCLES - 1))
                begin
                    state_d = NRCC_ST_TILE;
                    cnt_d = '0;
                end
                else
                    cnt_d = cnt_q + 1'b1;
            end
            NRCC_ST_TILE:
            begin
                if (sys_src)
                begin
                    state_d = NRCC_ST_SYS;
                    cnt_d = '0;
                end
                else if (tile_src)
                    cnt_d = '0;
                else if (us_tick)
                begin
                    if (cnt_q == CW'(TILE_RESET_US - 1))
                        state_d = NRCC_ST_RUN;
                    else
                        cnt_d = cnt_q + 1'b1;
                end
            end
        endcase
    end

    // Watchdog counts millisecond ticks while the tiles run.
    always_comb
    begin
        wdog_cnt_d = wdog_cnt_q;
        wdog_exp_d = 1'b0;
        if (!wdog_enable || wdog_kick || state_q != NRCC_ST_RUN)
            wdog_cnt_d = 16'h0000;
        else if (ms_tick)
        begin
            if (wdog_cnt_q == WDOG_TIMEOUT_MS - 16'h0001)
            begin
                wdog_cnt_d = 16'h0000;
                wdog_exp_d = 1'b1;
            end
            else
                wdog_cnt_d = wdog_cnt_q + 16'h0001;
        end
    end

    // Register writes; a system reset restores the control fields.
    always_comb
    begin
        mode_d = mode_q;
        oe_d = oe_q;
        usb_en_d = usb_en_q;
        usb_acc_d = usb_acc_q;
        freq_d = freq_q;
        if (state_d == NRCC_ST_SYS && state_q != NRCC_ST_SYS)
        begin
            mode_d = NRCC_MODE_RST;
            oe_d = !NRCC_MODE_TRI_RST;
            usb_en_d = NRCC_USB_EN_RST;
            usb_acc_d = NRCC_USB_ACC_RST;
        end
        else if (wr_rm)
        begin
            mode_d = cfg_wdata[NRCC_POS_MODE +: 2];
            oe_d = !cfg_wdata[NRCC_BIT_MODE_TRI];
            usb_en_d = cfg_wdata[NRCC_BIT_USB_EN];
            usb_acc_d = cfg_wdata[NRCC_BIT_USB_ACC];
        end
        if (wr_freq && freq_ok)
            freq_d = cfg_wdata[6:0];
    end

    // Answers: reset-bit writes are silent, bad writes are refused.
    always_comb
    begin
        rsp_valid_d = cfg_valid && (!cfg_write || cfg_resp_req);
        if (sw_sys || sw_tile)
            rsp_valid_d = 1'b0;
        rsp_nack_d = 1'b0;
        rsp_rdata_d = 32'h00000000;
        if (cfg_addr == NRCC_REG_RESET_MODE)
        begin
            rsp_rdata_d[NRCC_BIT_MODE_TRI] = !oe_q;
            rsp_rdata_d[NRCC_POS_MODE +: 2] = mode_q;
            rsp_rdata_d[NRCC_BIT_USB_ACC] = usb_acc_q;
            rsp_rdata_d[NRCC_BIT_USB_EN] = usb_en_q;
        end
        else if (cfg_addr == NRCC_REG_OSC_FREQ)
        begin
            rsp_rdata_d[6:0] = freq_q;
            rsp_nack_d = cfg_write && !freq_ok;
        end
        else
            rsp_nack_d = 1'b1;
        if (cfg_write)
            rsp_rdata_d = 32'h00000000;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= NRCC_ST_SYS;
            cnt_q <= '0;
            wdog_cnt_q <= 16'h0000;
            wdog_exp_q <= 1'b0;
            mode_q <= NRCC_MODE_RST;
            oe_q <= !NRCC_MODE_TRI_RST;
            usb_en_q <= NRCC_USB_EN_RST;
            usb_rst_q <= !NRCC_USB_EN_RST;
            usb_acc_q <= NRCC_USB_ACC_RST;
            freq_q <= NRCC_FREQ_RST;
            rsp_valid_q <= 1'b0;
            rsp_nack_q <= 1'b0;
            rsp_rdata_q <= 32'h00000000;
            sys_rst_q <= 1'b1;
            tile_rst_q <= 1'b1;
            rtc_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wdog_cnt_q <= wdog_cnt_d;
            wdog_exp_q <= wdog_exp_d;
            mode_q <= mode_d;
            oe_q <= oe_d;
            usb_en_q <= usb_en_d;
            usb_rst_q <= !usb_en_d;
            usb_acc_q <= usb_acc_d;
            freq_q <= freq_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_nack_q <= rsp_nack_d;
            rsp_rdata_q <= rsp_rdata_d;
            sys_rst_q <= state_d == NRCC_ST_SYS;
            tile_rst_q <= state_d != NRCC_ST_RUN;
            rtc_q <= ms_tick;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_nack = rsp_nack_q;
    assign rsp_rdata = rsp_rdata_q;
    assign sys_reset = sys_rst_q;
    assign tile_reset = tile_rst_q;
    assign mode_pins_out = mode_q;
    assign mode_pins_oe = oe_q;
    assign usb_enable = usb_en_q;
    assign usb_regs_reset = usb_rst_q;
    assign usb_reg_access_en = usb_acc_q;
    assign sleep_rtc_tick = rtc_q;
endmodule
`default_nettype wire

// ---- nrcc_node_reset_props.sv ----
// Purpose: Port assertions for the node reset block.
// Assumes: One clock domain, reset asynchronous active high.
// Notes: Attached to every instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module nrcc_node_reset_props
    import nrcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Reset sources.
    input wire logic ext_reset_n,
    input wire logic brownout,
    input wire logic sleep_seq,
    input wire logic clk_src_change,
    // Configuration request and response.
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic cfg_resp_req,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_nack,
    // Outputs.
    input wire logic sys_reset,
    input wire logic tile_reset,
    input wire logic usb_enable,
    input wire logic usb_regs_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic wr_rst_mode;
    assign wr_rst_mode = cfg_valid && cfg_write
        && cfg_addr == NRCC_REG_RESET_MODE;

    rsp_has_req_a: assert property (rsp_valid |-> $past(cfg_valid))
        else $error("response without request");
    rst_write_quiet_a: assert property (wr_rst_mode
        && cfg_wdata[1:0] != 2'h0 |=> !rsp_valid)
        else $error("response after reset write");
    read_answered_a: assert property (cfg_valid && !cfg_write
        && (cfg_addr == NRCC_REG_RESET_MODE
        || cfg_addr == NRCC_REG_OSC_FREQ)
        |=> rsp_valid && !rsp_nack)
        else $error("read not answered");
    unmapped_nack_a: assert property (cfg_valid && !cfg_write
        && cfg_addr != NRCC_REG_RESET_MODE
        && cfg_addr != NRCC_REG_OSC_FREQ |=> rsp_valid && rsp_nack)
        else $error("unmapped read not refused");
    freq_refused_a: assert property (cfg_valid && cfg_write
        && cfg_resp_req && cfg_addr == NRCC_REG_OSC_FREQ
        && (cfg_wdata < 32'h5 || cfg_wdata > 32'h64)
        |=> rsp_valid && rsp_nack)
        else $error("bad frequency not refused");
    sys_source_a: assert property (!ext_reset_n || brownout
        |=> sys_reset)
        else $error("system source ignored");
    tile_source_a: assert property (sleep_seq || clk_src_change
        |=> tile_reset)
        else $error("tile source ignored");
    sys_covers_tile_a: assert property (sys_reset |-> tile_reset)
        else $error("system reset without tile reset");
    sys_held_a: assert property ($rose(sys_reset) |-> sys_reset[*8])
        else $error("system reset too short");
    usb_reset_a: assert property (usb_regs_reset != usb_enable)
        else $error("usb register reset wrong");
endmodule
bind nrcc_node_reset nrcc_node_reset_props i_props (.clk(clk),
    .reset(reset), .ext_reset_n(ext_reset_n), .brownout(brownout),
    .sleep_seq(sleep_seq), .clk_src_change(clk_src_change),
    .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_resp_req(cfg_resp_req), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .sys_reset(sys_reset), .tile_reset(tile_reset),
    .usb_enable(usb_enable), .usb_regs_reset(usb_regs_reset));
`default_nettype wire

// ---- nrcc_node_reset_tb.sv ----
// Purpose: Self-checking bench for the node reset block.
// Assumes: Short counts: 64 reset cycles, 2 us tile, 2 ms watchdog.
// Notes: Register accesses are single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module nrcc_node_reset_tb
    import nrcc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    logic brownout = 1'b0;
    logic sleep_seq = 1'b0;
    logic clk_src_change = 1'b0;
    logic wdog_enable = 1'b0;
    logic wdog_kick = 1'b0;
    logic cfg_resp_req = 1'b1;
    logic cfg_valid = 1'b0;
    logic cfg_write = 1'b0;
    logic [7:0] cfg_addr = 8'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic rsp_valid, rsp_nack, sys_reset, tile_reset;
    logic [31:0] rsp_rdata;
    logic [1:0] mode_pins_out;
    logic mode_pins_oe, usb_enable, usb_regs_reset, usb_reg_access_en;
    logic sleep_rtc_tick;
    logic [31:0] fq [5] = '{32'h4, 32'h5, 32'h65, 32'h64, 32'h119};
    logic [4:0] nk = 5'h15;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    int m;
    int rtc_n = 0;

    always #12.5 clk = ~clk;

    nrcc_node_reset #(.SYS_RESET_CYCLES(64), .TILE_RESET_US(2),
        .WDOG_TIMEOUT_MS(16'h2)) i_dut (.clk(clk), .reset(reset),
        .ext_reset_n(ext_reset_n), .brownout(brownout),
        .sleep_seq(sleep_seq), .clk_src_change(clk_src_change),
        .wdog_enable(wdog_enable), .wdog_kick(wdog_kick),
        .cfg_valid(cfg_valid), .cfg_write(cfg_write),
        .cfg_resp_req(cfg_resp_req), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata),
        .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
        .sys_reset(sys_reset), .tile_reset(tile_reset),
        .mode_pins_out(mode_pins_out), .mode_pins_oe(mode_pins_oe),
        .usb_enable(usb_enable), .usb_regs_reset(usb_regs_reset),
        .usb_reg_access_en(usb_reg_access_en),
        .sleep_rtc_tick(sleep_rtc_tick));

    task wrap_up();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask

    // One strobe; the response is settled when the task returns.
    task rq(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cfg_valid <= 1'b1;
        cfg_write <= w;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_valid <= 1'b0;
        #1;
    endtask

    task idle();
        while (tile_reset !== 1'b0)
            @(posedge clk);
    endtask

    task src(input int k);
        @(posedge clk);
        case (k)
            0: brownout <= 1'b1;
            1: ext_reset_n <= 1'b0;
            2: sleep_seq <= 1'b1;
            default: clk_src_change <= 1'b1;
        endcase
        @(posedge clk);
        brownout <= 1'b0;
        ext_reset_n <= 1'b1;
        sleep_seq <= 1'b0;
        clk_src_change <= 1'b0;
        #1;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            wrap_up();
        end
    end

    always @(posedge clk)
    begin
        if (sleep_rtc_tick === 1'b1)
            rtc_n++;
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (62) @(posedge clk);
        #1;
        chk(32'(sys_reset), 32'h1);
        repeat (4) @(posedge clk);
        #1;
        chk(32'({sys_reset, tile_reset}), 32'h1);
        idle();
        rq(1'b0, NRCC_REG_OSC_FREQ, 32'h0);
        chk({rsp_valid, rsp_rdata[30:0]}, 32'h80000019);
        rq(1'b0, NRCC_REG_RESET_MODE, 32'h0);
        chk(rsp_rdata, 32'h01000000);
        for (n = 0; n < 5; n++)
        begin
            rq(1'b1, NRCC_REG_OSC_FREQ, fq[n]);
            chk(32'({rsp_valid, rsp_nack}), 32'({1'b1, nk[n]}));
        end
        rq(1'b0, NRCC_REG_OSC_FREQ, 32'h0);
        chk(rsp_rdata, 32'h64);
        @(posedge clk);
        cfg_resp_req <= 1'b0;
        rq(1'b1, NRCC_REG_OSC_FREQ, 32'h30);
        chk(32'(rsp_valid), 32'h0);
        @(posedge clk);
        cfg_resp_req <= 1'b1;
        rq(1'b0, NRCC_REG_OSC_FREQ, 32'h0);
        chk(rsp_rdata, 32'h30);
        rq(1'b1, NRCC_REG_RESET_MODE, 32'h0002000c);
        chk(32'({mode_pins_out, mode_pins_oe, usb_enable, usb_regs_reset,
            usb_reg_access_en}), 32'h2d);
        rq(1'b0, NRCC_REG_RESET_MODE, 32'h0);
        chk(rsp_rdata, 32'h0002000c);
        rq(1'b1, NRCC_REG_RESET_MODE, 32'h01010000);
        chk(32'({mode_pins_out, mode_pins_oe, usb_enable, usb_regs_reset,
            usb_reg_access_en}), 32'h12);
        rq(1'b0, 8'h52, 32'h0);
        chk(32'({rsp_valid, rsp_nack}), 32'h3);
        rq(1'b1, NRCC_REG_RESET_MODE, 32'h2);
        chk(32'({rsp_valid, sys_reset, tile_reset}), 32'h1);
        idle();
        rq(1'b1, NRCC_REG_RESET_MODE, 32'hc);
        rq(1'b1, NRCC_REG_RESET_MODE, 32'h1);
        chk(32'({rsp_valid, sys_reset, tile_reset}), 32'h3);
        idle();
        rq(1'b0, NRCC_REG_RESET_MODE, 32'h0);
        chk(rsp_rdata, 32'h01000000);
        for (n = 0; n < 4; n++)
        begin
            src(n);
            chk(32'({sys_reset, tile_reset}), n < 2 ? 32'h3 : 32'h1);
            idle();
        end
        src(0);
        repeat (40) @(posedge clk);
        src(0);
        repeat (40) @(posedge clk);
        #1;
        chk(32'(sys_reset), 32'h1);
        idle();
        rq(1'b1, NRCC_REG_OSC_FREQ, 32'h5);
        @(posedge clk);
        wdog_enable <= 1'b1;
        m = rtc_n;
        for (n = 0; n < 3; n++)
        begin
            repeat (4000) @(posedge clk);
            wdog_kick <= 1'b1;
            @(posedge clk);
            wdog_kick <= 1'b0;
        end
        #1;
        chk(32'(sys_reset), 32'h0);
        chk(32'(rtc_n - m >= 2 && rtc_n - m <= 3), 32'h1);
        n = 0;
        while (sys_reset !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 5000 && n <= 10010), 32'h1);
        wdog_enable <= 1'b0;
        idle();
        wrap_up();
    end
endmodule
`default_nettype wire
